/* File: tb/scg_ctrl_properties.sv */
// Port-level checker for the sample-clock generator control block.
// Assumes one clock domain, mclk, with synchronous active-low reset_n.
`timescale 1ns/1ps
`default_nettype none
module scg_ctrl_properties
#(
  parameter MAG_W = 8  // Phase magnitude width
)
(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        ctrl_wr,
  input wire logic        ctrl_rd,
  input wire logic        ctrl_resp_valid,
  input wire logic        gen_a_reference_sel,
  input wire logic        gen_a_video_mode,
  input wire logic [16:0] gen_a_base_rate_hz,
  input wire logic [3:0]  gen_a_divisor,
  input wire logic        gen_a_eight_sevenths_en,
  input wire logic [16:0] gen_a_bitclk_hz,
  input wire logic        gen_a_bitclk_x128,
  input wire logic        phase_step_advance,
  input wire logic        phase_step_retard
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire strobe   = ctrl_wr | ctrl_rd;                        // Any request
  wire step_any = phase_step_advance | phase_step_retard;   // Any step pulse
  ////////////////////////////////////////////////////////////////////////////
  resp_follows_a: assert property (strobe |=> ctrl_resp_valid)
    else $error("response pulse missing");
  resp_caused_a: assert property (ctrl_resp_valid |-> $past(strobe))
    else $error("response without request");
  // Steps come at most once per master-clock step tick, far above 8 cycles
  step_spacing_a: assert property (step_any |=> !step_any [*8])
    else $error("phase steps too close");
  step_dir_a: assert property (!(phase_step_advance && phase_step_retard))
    else $error("advance and retard together");
  ref_freeze_a: assert property (gen_a_reference_sel |-> !step_any)
    else $error("phase step under sync reference");
  eight_ref_a: assert property (gen_a_eight_sevenths_en |-> !gen_a_reference_sel)
    else $error("8/7 active under sync reference");
  video_nobit_a: assert property (gen_a_video_mode |->
      gen_a_bitclk_hz == 17'h00000 && !gen_a_bitclk_x128 && gen_a_reference_sel)
    else $error("bit clock in video lock");
  x128_nobit_a: assert property (gen_a_bitclk_x128 |-> gen_a_bitclk_hz == 17'h00000)
    else $error("table bit clock with 128x");
  novideo_sel_a: assert property (!gen_a_video_mode |->
      gen_a_divisor == 4'h0 && gen_a_base_rate_hz == 17'h00000)
    else $error("video selection outside video lock");
  cover property (ctrl_resp_valid);
  cover property (phase_step_retard);
  cover property (phase_step_advance);
  cover property (gen_a_video_mode);
endmodule
bind scg_ctrl scg_ctrl_properties #(.MAG_W(MAG_W)) u_props (.mclk(mclk), .reset_n(reset_n),
  .ctrl_wr(ctrl_wr), .ctrl_rd(ctrl_rd), .ctrl_resp_valid(ctrl_resp_valid),
  .gen_a_reference_sel(gen_a_reference_sel), .gen_a_video_mode(gen_a_video_mode),
  .gen_a_base_rate_hz(gen_a_base_rate_hz), .gen_a_divisor(gen_a_divisor),
  .gen_a_eight_sevenths_en(gen_a_eight_sevenths_en), .gen_a_bitclk_hz(gen_a_bitclk_hz),
  .gen_a_bitclk_x128(gen_a_bitclk_x128), .phase_step_advance(phase_step_advance),
  .phase_step_retard(phase_step_retard));
`default_nettype wire

/* File: tb/scg_ctrl_tb.sv */
// Self-checking bench for the sample-clock generator control block.
// Assumes scg_ctrl, its checker and the pin model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module scg_ctrl_tb;
  logic        mclk = 1'b0, reset_n = 1'b0, powerdown_pin_n = 1'b1, bus_master = 1'b1;
  logic        slot0_start = 1'b0, gen_a_enable = 1'b1, ctrl_wr = 1'b0, ctrl_rd = 1'b0;
  logic [4:0]  ctrl_addr = 5'h00;
  logic [15:0] ctrl_wdata = 16'h0000;
  wire         master_clk_in, frame_sync_in, ctrl_resp_valid, gen_a_reference_sel;
  wire         gen_a_video_mode, gen_a_video_standard_sel, gen_a_eight_sevenths_en;
  wire         gen_a_bitclk_x128, gen_a_loop_gain_sel, gen_a_conv_pin_x128;
  wire         phase_step_advance, phase_step_retard;
  wire [15:0]  ctrl_rdata, gen_a_sample_rate_value, gen_b_mode;
  wire [16:0]  gen_a_base_rate_hz, gen_a_bitclk_hz;
  wire [3:0]   gen_a_divisor;
  int          error_cnt = 0, num_checks = 0, adv_n = 0, ret_n = 0, a0, r0, i;
  logic [15:0] q, snap;  // Last answer, held snapshot
  logic [16:0] bases [6] = '{17'h0BB80, 17'h07D00, 17'h0AC44, 17'h072D8, 17'h0BB80, 17'h0AC18};

  always #4 mclk = ~mclk;
  // Step pulse tallies; scenarios work on differences
  always @(posedge mclk)
  begin
    adv_n <= adv_n + int'(phase_step_advance);
    ret_n <= ret_n + int'(phase_step_retard);
  end

  scg_pin_model u_pins (.master_clk_in(master_clk_in), .frame_sync_in(frame_sync_in));
  scg_ctrl #(.MAG_W(8)) dut (.mclk(mclk), .reset_n(reset_n), .powerdown_pin_n(powerdown_pin_n),
    .master_clk_in(master_clk_in), .frame_sync_in(frame_sync_in), .bus_master(bus_master),
    .slot0_start(slot0_start), .gen_a_enable(gen_a_enable), .ctrl_wr(ctrl_wr),
    .ctrl_rd(ctrl_rd), .ctrl_addr(ctrl_addr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
    .ctrl_resp_valid(ctrl_resp_valid), .gen_a_reference_sel(gen_a_reference_sel),
    .gen_a_video_mode(gen_a_video_mode), .gen_a_video_standard_sel(gen_a_video_standard_sel),
    .gen_a_base_rate_hz(gen_a_base_rate_hz), .gen_a_divisor(gen_a_divisor),
    .gen_a_sample_rate_value(gen_a_sample_rate_value),
    .gen_a_eight_sevenths_en(gen_a_eight_sevenths_en), .gen_a_bitclk_hz(gen_a_bitclk_hz),
    .gen_a_bitclk_x128(gen_a_bitclk_x128), .gen_a_loop_gain_sel(gen_a_loop_gain_sel),
    .gen_a_conv_pin_x128(gen_a_conv_pin_x128), .phase_step_advance(phase_step_advance),
    .phase_step_retard(phase_step_retard), .gen_b_mode(gen_b_mode));
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One compare for every kind of result
  task automatic cmp(input string nm, input logic [16:0] exp, input logic [16:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // One register access; answer lands in q
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    ctrl_wr <= w;
    ctrl_rd <= !w;
    ctrl_addr <= a;
    ctrl_wdata <= d;
    @(posedge mclk);
    ctrl_wr <= 1'b0;
    ctrl_rd <= 1'b0;
    #1;
    cmp("resp_valid", 17'h00001, {16'h0000, ctrl_resp_valid});
    q = ctrl_rdata;
  endtask
  // Bounded wait for a number of step pulses
  task automatic wait_steps(input int na, input int nr);
    int k;
    for (k = 0; k < 3000 && (adv_n - a0 < na || ret_n - r0 < nr); k++)
      @(posedge mclk);
    if (k == 3000)
    begin
      error_cnt++;
      summarize();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #400000;
    error_cnt++;
    summarize();
  end
  initial
  begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    idle(3);
    // Defaults after reset
    cmp("rate_out", 17'h0BB80, gen_a_sample_rate_value);
    acc(0, 5'h10, 16'h0000);
    cmp("mode", 17'h000FF, q);
    acc(0, 5'h11, 16'h0000);
    cmp("rate", 17'h0BB80, q);
    acc(0, 5'h12, 16'h0000);
    cmp("phase", 17'h00000, q);
    // Sample rate: old word returned, new value in force, both range ends
    acc(1, 5'h11, 16'h0FA0);
    cmp("old_rate", 17'h0BB80, q);
    acc(1, 5'h11, 16'hD2F0);
    idle(2);
    cmp("rate_out", 17'h0D2F0, gen_a_sample_rate_value);
    acc(0, 5'h11, 16'h0000);
    cmp("rate", 17'h0D2F0, q);
    // Second generator mode, reserved bits dropped; unmapped place
    acc(1, 5'h13, 16'hFFFF);
    cmp("old_b", 17'h000FF, q);
    acc(0, 5'h13, 16'h0000);
    cmp("mode_b", 17'h0FCFF, q);
    cmp("mode_b_out", 17'h0FCFF, gen_b_mode);
    acc(0, 5'h1F, 16'h0000);
    cmp("unmapped", 17'h00000, q);
    // Bit clock table, offset, 128x code
    acc(1, 5'h10, 16'h1003);
    idle(2);
    cmp("bitclk", 17'd9800, gen_a_bitclk_hz);
    acc(1, 5'h10, 16'h4003);
    idle(2);
    cmp("bitclk", 17'd9600, gen_a_bitclk_hz);
    cmp("video", 17'h00000, {16'h0000, gen_a_video_mode});
    acc(1, 5'h10, 16'h000C);
    idle(2);
    cmp("bitclk_rsvd", 17'h00000, gen_a_bitclk_hz);
    acc(1, 5'h10, 16'h24FF);
    idle(2);
    cmp("x128", 17'h00001, {16'h0000, gen_a_bitclk_x128});
    cmp("gain", 17'h00001, {16'h0000, gen_a_loop_gain_sel});
    cmp("conv_pin", 17'h00001, {16'h0000, gen_a_conv_pin_x128});
    // Video lock: every NTSC base code, legal divisor each
    for (i = 0; i < 6; i++)
    begin
      acc(1, 5'h10, 16'hC000 | 16'(i << 4) | 16'(i));
      idle(2);
      cmp("base", bases[i], gen_a_base_rate_hz);
      cmp("divisor", 17'(i + 1), gen_a_divisor);
      cmp("video", 17'h00001, {16'h0000, gen_a_video_mode});
    end
    cmp("standard", 17'h00000, {16'h0000, gen_a_video_standard_sel});
    acc(1, 5'h10, 16'hC087);
    idle(2);
    cmp("standard", 17'h00001, {16'h0000, gen_a_video_standard_sel});
    cmp("divisor", 17'h00008, gen_a_divisor);
    // 8/7 scaling only under master reference
    acc(1, 5'h10, 16'h8800);
    idle(2);
    cmp("x87", 17'h00000, {16'h0000, gen_a_eight_sevenths_en});
    cmp("ref_sel", 17'h00001, {16'h0000, gen_a_reference_sel});
    acc(1, 5'h10, 16'h0800);
    idle(2);
    cmp("x87", 17'h00001, {16'h0000, gen_a_eight_sevenths_en});
    cmp("ref_sel", 17'h00000, {16'h0000, gen_a_reference_sel});
    // Power-down holds defaults and ignores writes
    powerdown_pin_n <= 1'b0;
    idle(4);
    acc(1, 5'h11, 16'h1F40);
    acc(0, 5'h11, 16'h0000);
    cmp("rate_pd", 17'h0BB80, q);
    acc(0, 5'h10, 16'h0000);
    cmp("mode_pd", 17'h000FF, q);
    powerdown_pin_n <= 1'b1;
    idle(4);
    // Disabled generator refuses phase writes
    gen_a_enable <= 1'b0;
    idle(2);
    r0 = ret_n;
    acc(1, 5'h12, 16'h0103);
    idle(100);
    cmp("retard_off", 17'h00000, 17'(ret_n - r0));
    gen_a_enable <= 1'b1;
    // Retard three steps, nothing more
    a0 = adv_n;
    r0 = ret_n;
    acc(1, 5'h12, 16'h0103);
    wait_steps(0, 3);
    idle(200);
    cmp("retard", 17'h00003, 17'(ret_n - r0));
    cmp("advance", 17'h00000, 17'(adv_n - a0));
    // Back-to-back writes: second replaces the pending count
    a0 = adv_n;
    r0 = ret_n;
    @(posedge mclk);
    ctrl_wr <= 1'b1;
    ctrl_addr <= 5'h12;
    ctrl_wdata <= 16'h00FF;
    acc(1, 5'h12, 16'h0002);
    cmp("old_phase", 17'h000FF, q);
    wait_steps(2, 0);
    idle(200);
    cmp("advance", 17'h00002, 17'(adv_n - a0));
    cmp("retard", 17'h00000, 17'(ret_n - r0));
    // Sync reference freezes the count
    acc(1, 5'h10, 16'h8000);
    acc(1, 5'h12, 16'h0110);
    r0 = ret_n;
    idle(300);
    cmp("frozen", 17'h00000, 17'(ret_n - r0));
    acc(1, 5'h10, 16'h0000);
    // Read-back is the remainder at the last frame mark
    acc(1, 5'h12, 16'h0150);
    @(posedge mclk);
    slot0_start <= 1'b1;
    @(posedge mclk);
    slot0_start <= 1'b0;
    acc(0, 5'h12, 16'h0000);
    snap = q;
    cmp("snap_near", 17'h00001, {16'h0000, snap >= 16'h014E && snap <= 16'h0150});
    idle(600);
    acc(0, 5'h12, 16'h0000);
    cmp("snap_held", {1'b0, snap}, {1'b0, q});
    bus_master <= 1'b0;
    idle(600);
    acc(0, 5'h12, 16'h0000);
    cmp("snap_slave", 17'h00001, {16'h0000, q < snap && q[8]});
    summarize();
  end
endmodule
`default_nettype wire

/* File: tb/scg_pin_model.sv */
// Far-side pin model: master clock oscillator and slave frame sync.
// Assumes the bench samples both pins only through the block.
`timescale 1ns/1ps
`default_nettype none
module scg_pin_model
#(
  parameter real XTAL_HALF_NS = 20.345,  // Half period of 24.576 MHz
  parameter int  FRAME_NS     = 4000     // Frame spacing, 500 mclk cycles
)
(
  output var logic master_clk_in,
  output var logic frame_sync_in
);
  ////////////////////////////////////////////////////////////////////////////
  // Free-running oscillator, unrelated in phase to mclk
  initial master_clk_in = 1'b0;
  always #(XTAL_HALF_NS) master_clk_in = ~master_clk_in;
  // Frame sync pulse, wide enough to survive the synchroniser
  initial
  begin
    frame_sync_in = 1'b0;
    forever
    begin
      #(FRAME_NS - 100);
      frame_sync_in = 1'b1;
      #100;
      frame_sync_in = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/scg_ctrl.v */
// Control logic of the first programmable sample-clock generator:
// mode, sample-rate and phase-shift registers plus the second
// generator's mode register. Assumes the serial control port logic
// runs on mclk and hands over decoded words as one-cycle strobes;
// pins arriving from outside are synchronised here.
//
// Contract
// - offset bit adds 200 Hz to bit clock
// - both nibbles all ones gives 128x bit clock
// - video lock uses modifier for conversion rate
// - modifier bit 7 picks NTSC or PAL
// - modifier bits 6..4 pick the base rate
// - bits 3..0 pick divisor one to eight
// - mode register resets 00FF, frozen while held
// - sample-rate field gives rate, one hertz per LSB
// - sample-rate register resets BB80, frozen while held
// - direction bit zero advances, one retards
// - each magnitude LSB is 0.12 degrees
// - magnitude decrements one LSB at 3.072 MHz
// - phase read returns remainder snapshot at frame
// - new phase write replaces remaining count
// - write returns pre-write contents in next frame
// - phase register cleared while held or disabled
// - second generator mode register field layout
// - second generator fields exported for its synthesiser
// - sync reference ignores rate, phase and 8/7
// - 8/7 bit scales rate under master reference
// - lower nibble picks bit clock outside video
`timescale 1ns/1ps
`default_nettype none
`include "scg_regs.vh"

module scg_ctrl
#(
  parameter MAG_W = `SCG_PHASE_MAG_W  // Phase magnitude width
)
(
  input  wire        mclk,                    // 125 MHz system clock
  input  wire        reset_n,                 // Synchronous reset, active low
  input  wire        powerdown_pin_n,         // Power-down pin, async
  input  wire        master_clk_in,           // Master clock pin, async
  input  wire        frame_sync_in,           // Frame sync pin, async
  input  wire        bus_master,              // Port is frame master
  input  wire        slot0_start,             // Slot 0 begins, master mode
  input  wire        gen_a_enable,            // Generator enable bit
  input  wire        ctrl_wr,                 // Register write strobe
  input  wire        ctrl_rd,                 // Register read strobe
  input  wire [4:0]  ctrl_addr,               // Register address
  input  wire [15:0] ctrl_wdata,              // Write data
  output reg  [15:0] ctrl_rdata,              // Read or pre-write word
  output reg         ctrl_resp_valid,         // Response pulse
  output reg         gen_a_reference_sel,     // 1: locked to sync input
  output reg         gen_a_video_mode,        // Video lock active
  output reg         gen_a_video_standard_sel,// 0 NTSC, 1 PAL
  output reg  [16:0] gen_a_base_rate_hz,      // Video base rate, 0 invalid
  output reg  [3:0]  gen_a_divisor,           // Video divisor, 0 invalid
  output reg  [15:0] gen_a_sample_rate_value, // Rate under master reference
  output reg         gen_a_eight_sevenths_en, // 8/7 scaling in force
  output reg  [16:0] gen_a_bitclk_hz,         // Bit clock, 0 when none
  output reg         gen_a_bitclk_x128,       // Bit clock is 128x conversion
  output reg         gen_a_loop_gain_sel,     // Loop gain select
  output reg         gen_a_conv_pin_x128,     // Conversion pin at 128x
  output reg         phase_step_advance,      // One 0.12 degree advance
  output reg         phase_step_retard,       // One 0.12 degree retard
  output reg  [15:0] gen_b_mode               // Second generator mode fields
);

  ////////////////////////////////////////////////////////////////////
  // Constants

  // Master clock edges per phase step
  localparam integer STEP_DIV = `SCG_XTAL_HZ / `SCG_STEP_HZ;
  localparam integer STEP_DIV_M1 = STEP_DIV - 1;
  // Counter is four bits wide; the ratio must stay at sixteen or below
  localparam [3:0]   STEP_DIV_LAST = STEP_DIV_M1[3:0];

  ////////////////////////////////////////////////////////////////////
  // Lookup functions

  // Base rate for a video code; NTSC-only codes invalid under PAL
  function [16:0] base_rate;
    input       pal;
    input [2:0] code;
    begin
      case (code)
        3'h0:    base_rate = `SCG_BASE_48000;
        3'h1:    base_rate = `SCG_BASE_32000;
        3'h2:    base_rate = `SCG_BASE_44100;
        3'h3:    base_rate = `SCG_BASE_29400;
        3'h4:    base_rate = pal ? 17'h00000 : `SCG_BASE_48000;
        3'h5:    base_rate = pal ? 17'h00000 : `SCG_BASE_44056;
        default: base_rate = 17'h00000;
      endcase
    end
  endfunction

  // Bit clock rate for a lower-nibble code, reserved codes give 0
  function [16:0] bitclk_rate;
    input [3:0] code;
    input       plus200;
    reg   [16:0] base;
    begin
      base = 17'h00000;
      if (code <= `SCG_BITCLK_MAX_CODE)
      begin
        base = `SCG_BITCLK_STEP_HZ * ({13'h0000, code} + 17'h00001);
        if (plus200)
          base = base + `SCG_BITCLK_OFFSET_HZ;
      end
      bitclk_rate = base;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two flops each

  reg [1:0] pd_sync;      // Power-down pin
  reg [1:0] xtal_sync;    // Master clock pin
  reg [1:0] fs_sync;      // Frame sync pin
  reg       xtal_last;    // Previous synced master clock
  reg       fs_last;      // Previous synced frame sync

  // First flop feeds only the second
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      pd_sync   <= 2'h0;
      xtal_sync <= 2'h0;
      fs_sync   <= 2'h0;
      xtal_last <= 1'b0;
      fs_last   <= 1'b0;
    end
    else
    begin
      pd_sync   <= {pd_sync[0], powerdown_pin_n};
      xtal_sync <= {xtal_sync[0], master_clk_in};
      fs_sync   <= {fs_sync[0], frame_sync_in};
      xtal_last <= xtal_sync[1];
      fs_last   <= fs_sync[1];
    end
  end

  // Registers held at default while the power-down pin is low
  wire hold      = ~pd_sync[1];
  wire xtal_rise = xtal_sync[1] & ~xtal_last;
  wire fs_rise   = fs_sync[1] & ~fs_last;
  // Frame mark for the read-back snapshot
  wire frame_mark = bus_master ? slot0_start : fs_rise;

  ////////////////////////////////////////////////////////////////////
  // Register file

  reg [15:0]      mode_a;       // Generator A mode
  reg [15:0]      sample_rate;  // Generator A rate
  reg             phase_dir;    // Direction bit
  reg [MAG_W-1:0] phase_mag;    // Remaining magnitude
  reg [15:0]      mode_b;       // Generator B mode
  reg [15:0]      phase_snap;   // Remainder seen at last frame
  reg [3:0]       xtal_count;   // Master clock edges toward a step

  wire wr_mode_a = ctrl_wr & (ctrl_addr == `SCG_ADDR_GEN_A_MODE);
  wire wr_rate   = ctrl_wr & (ctrl_addr == `SCG_ADDR_SAMPLE_RATE);
  wire wr_phase  = ctrl_wr & (ctrl_addr == `SCG_ADDR_PHASE_SHIFT);
  wire wr_mode_b = ctrl_wr & (ctrl_addr == `SCG_ADDR_GEN_B_MODE);
  // Reserved upper bits of the phase word always read as zero
  wire [15:0] phase_word = {7'h00, phase_dir, phase_mag};
  // Phase register is dead while the generator is off
  wire phase_hold = hold | ~gen_a_enable;
  wire ref_sync   = mode_a[`SCG_BIT_REF];
  wire step_tick  = xtal_rise & (xtal_count == STEP_DIV_LAST);

  // Mode and rate registers
  always @(posedge mclk)
  begin
    if (!reset_n || hold)
    begin
      mode_a      <= `SCG_RST_GEN_A_MODE;
      sample_rate <= `SCG_RST_SAMPLE_RATE;
      mode_b      <= `SCG_RST_GEN_B_MODE;
    end
    else
    begin
      if (wr_mode_a)
        mode_a <= ctrl_wdata & `SCG_MASK_MODE;
      if (wr_rate)
        sample_rate <= ctrl_wdata;
      if (wr_mode_b)
        mode_b <= ctrl_wdata & `SCG_MASK_MODE;
    end
  end

  // Master clock edge counter, one step per STEP_DIV edges
  // Edges are counted after the synchroniser, so the master clock
  // must stay well below half of mclk or edges go missing
  always @(posedge mclk)
  begin
    if (!reset_n)
      xtal_count <= 4'h0;
    else if (xtal_rise)
      xtal_count <= step_tick ? 4'h0 : xtal_count + 4'h1;
  end

  // Phase register; a write wins over a pending decrement
  always @(posedge mclk)
  begin
    if (!reset_n || phase_hold)
    begin
      phase_dir <= 1'b0;
      phase_mag <= {MAG_W{1'b0}};
    end
    else if (wr_phase)
    begin
      phase_dir <= ctrl_wdata[`SCG_BIT_PHASE_DIR];
      phase_mag <= ctrl_wdata[MAG_W-1:0];
    end
    else if (step_tick && !ref_sync && phase_mag != {MAG_W{1'b0}})
      phase_mag <= phase_mag - {{(MAG_W-1){1'b0}}, 1'b1};
  end

  // Step pulses; each stands for 0.12 degrees of phase
  // No pulse when a write lands on a tick, as the write wins
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      phase_step_advance <= 1'b0;
      phase_step_retard  <= 1'b0;
    end
    else
    begin
      // Under sync reference the phase is locked and never shifted
      phase_step_advance <= step_tick & ~ref_sync & ~phase_hold & ~wr_phase
                            & (phase_mag != {MAG_W{1'b0}}) & ~phase_dir;
      phase_step_retard  <= step_tick & ~ref_sync & ~phase_hold & ~wr_phase
                            & (phase_mag != {MAG_W{1'b0}}) & phase_dir;
    end
  end

  // Snapshot of the unprocessed shift at each frame mark
  // Cleared with the register, so a disabled generator reads zero
  always @(posedge mclk)
  begin
    if (!reset_n || phase_hold)
      phase_snap <= `SCG_RST_PHASE_SHIFT;
    else if (frame_mark)
      phase_snap <= phase_word;
  end

  ////////////////////////////////////////////////////////////////////
  // Read and write-return path

  reg [15:0] next_rdata;  // Word for the response slot

  // Write returns pre-write contents; read returns current view
  always @*
  begin
    case (ctrl_addr)
      `SCG_ADDR_GEN_A_MODE:  next_rdata = mode_a;
      `SCG_ADDR_SAMPLE_RATE: next_rdata = sample_rate;
      `SCG_ADDR_PHASE_SHIFT: next_rdata = ctrl_wr ? phase_word : phase_snap;
      `SCG_ADDR_GEN_B_MODE:  next_rdata = mode_b;
      default:               next_rdata = 16'h0000;
    endcase
  end

  // Response word stands until the next request
  // Port logic moves the word into the next frame's return slot
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      ctrl_rdata      <= 16'h0000;
      ctrl_resp_valid <= 1'b0;
    end
    else
    begin
      ctrl_resp_valid <= ctrl_wr | ctrl_rd;
      if (ctrl_wr || ctrl_rd)
        ctrl_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Decoded generator settings

  wire       video   = mode_a[`SCG_BIT_REF] & mode_a[`SCG_BIT_VID];
  wire [3:0] up_nib  = mode_a[`SCG_FLD_UP_NIB];
  wire [3:0] lo_nib  = mode_a[`SCG_FLD_LO_NIB];
  wire       x128    = (up_nib == `SCG_NIB_ALL_ONES) & (lo_nib == `SCG_NIB_ALL_ONES);

  // All decoded outputs come from flops
  always @(posedge mclk)
  begin
    if (!reset_n)
    begin
      gen_a_reference_sel      <= 1'b0;
      gen_a_video_mode         <= 1'b0;
      gen_a_video_standard_sel <= 1'b0;
      gen_a_base_rate_hz       <= 17'h00000;
      gen_a_divisor            <= 4'h0;
      gen_a_sample_rate_value  <= `SCG_RST_SAMPLE_RATE;
      gen_a_eight_sevenths_en  <= 1'b0;
      gen_a_bitclk_hz          <= 17'h00000;
      gen_a_bitclk_x128        <= 1'b0;
      gen_a_loop_gain_sel      <= 1'b0;
      gen_a_conv_pin_x128      <= 1'b0;
      gen_b_mode               <= `SCG_RST_GEN_B_MODE;
    end
    else
    begin
      gen_a_reference_sel      <= ref_sync;
      gen_a_video_mode         <= video;
      gen_a_video_standard_sel <= mode_a[`SCG_BIT_STD];
      gen_a_loop_gain_sel      <= mode_a[`SCG_BIT_PLLG];
      gen_a_conv_pin_x128      <= mode_a[`SCG_BIT_C128];
      gen_a_sample_rate_value  <= sample_rate;
      // 8/7 only under master reference
      gen_a_eight_sevenths_en  <= mode_a[`SCG_BIT_X87] & ~ref_sync;
      gen_b_mode               <= mode_b;
      if (video)
      begin
        // Caller owns legal base/divisor pairs; no check here
        gen_a_base_rate_hz <= base_rate(mode_a[`SCG_BIT_STD],
                                        mode_a[`SCG_FLD_BASE]);
        gen_a_divisor      <= (lo_nib <= `SCG_DIV_MAX_CODE) ? lo_nib + 4'h1 : 4'h0;
        gen_a_bitclk_hz    <= 17'h00000;
        gen_a_bitclk_x128  <= 1'b0;
      end
      else
      begin
        gen_a_base_rate_hz <= 17'h00000;
        gen_a_divisor      <= 4'h0;
        gen_a_bitclk_x128  <= x128;
        gen_a_bitclk_hz    <= x128 ? 17'h00000
                              : bitclk_rate(lo_nib, mode_a[`SCG_BIT_P200]);
      end
    end
  end

endmodule

`default_nettype wire

/* File: verilog/scg_regs.vh */
// Register map, field positions, reset values and rate constants
// for the sample-clock generator control block.
// Assumes inclusion by bare name from the design file.
`ifndef SCG_REGS_VH
`define SCG_REGS_VH

// Register addresses, 5-bit control-word address space
`define SCG_ADDR_W            5
`define SCG_ADDR_GEN_A_MODE   5'h10
`define SCG_ADDR_SAMPLE_RATE  5'h11
`define SCG_ADDR_PHASE_SHIFT  5'h12
`define SCG_ADDR_GEN_B_MODE   5'h13

// Reset values
`define SCG_RST_GEN_A_MODE    16'h00FF
`define SCG_RST_SAMPLE_RATE   16'hBB80
`define SCG_RST_PHASE_SHIFT   16'h0000
`define SCG_RST_GEN_B_MODE    16'h00FF

// Writable bit masks, reserved bits cleared
`define SCG_MASK_MODE         16'hFCFF
`define SCG_MASK_PHASE        16'h01FF

// Mode register fields (both generators)
`define SCG_BIT_REF           15
`define SCG_BIT_VID           14
`define SCG_BIT_PLLG          13
`define SCG_BIT_P200          12
`define SCG_BIT_X87           11
`define SCG_BIT_C128          10
`define SCG_BIT_STD           7
`define SCG_NIB_ALL_ONES      4'hF
`define SCG_FLD_UP_NIB        7:4
`define SCG_FLD_LO_NIB        3:0
`define SCG_FLD_BASE          6:4

// Phase register fields
`define SCG_BIT_PHASE_DIR     8
`define SCG_PHASE_MAG_W       8

// Bit clock table: step per code, highest legal code, offset
`define SCG_BITCLK_STEP_HZ    17'h00960
`define SCG_BITCLK_MAX_CODE   4'hB
`define SCG_BITCLK_OFFSET_HZ  17'h000C8

// Video-lock base rates in hertz
`define SCG_BASE_48000        17'h0BB80
`define SCG_BASE_32000        17'h07D00
`define SCG_BASE_44100        17'h0AC44
`define SCG_BASE_29400        17'h072D8
`define SCG_BASE_44056        17'h0AC18
`define SCG_DIV_MAX_CODE      4'h7

// Phase stepping: master clock rate, step rate, millidegrees per step
`define SCG_XTAL_HZ           24576000
`define SCG_STEP_HZ           3072000
`define SCG_STEP_MDEG         120

`endif
